// File: dv/msf_link_model.sv
// far-side equipment model: listener on the framer output, talker on its input
`timescale 1ns/1ps
module msf_link_model #(
	parameter int BIT_STD = 16,
	parameter int BIT_HS = 8
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hs_i,
	input wire logic tx_line_i,
	output logic rx_line_o
);
	logic [7:0] got[$];
	logic [7:0] sh;
	int bt;
	// the talker line idles high between characters and frames
	initial rx_line_o = 1'b1;
	// a low stop bit is logged as 00 so the bench sees it as a wrong character
	always begin
		@(posedge clock_i);
		if (resetn_i && !tx_line_i) begin
			bt = hs_i ? BIT_HS : BIT_STD;
			repeat (bt / 2) @(posedge clock_i);
			for (int i = 0; i < 8; i++) begin
				repeat (bt) @(posedge clock_i);
				sh[i] = tx_line_i;
			end
			repeat (bt) @(posedge clock_i);
			got.push_back(tx_line_i ? sh : 8'h00);
		end
	end
	task automatic send_byte(input logic [7:0] b);
		int n;
		logic [9:0] fr;
		n = hs_i ? BIT_HS : BIT_STD;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line_o <= fr[i];
			repeat (n) @(posedge clock_i);
		end
	endtask
endmodule // msf_link_model

// File: dv/msf_testbench.sv
// self-checking bench of the marine sentence framer
`timescale 1ns/1ps
`include "msf_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench import msf_pkg::*;;
	logic clock_i, resetn_i, hs_sel_i, tx_valid_i, tx_bang_i, rx_line_i;
	logic tx_ready_o, tx_line_o, tx_busy_o, tx_trunc_o, rx_char_valid_o, rx_fld_done_o;
	logic rx_fld_empty_o, rx_fld_num_o, rx_ok_o, rx_err_o;
	logic [7:0] tx_data_i, rx_char_o, rx_sum_o;
	logic [6:0] rx_field_o, rx_fld_len_o;
	logic [15:0] rx_talker_o;
	msf_kind_t tx_kind_i;
	msf_status_t rx_fld_status_o;
	int n_mismatch, comparisons, seed, n_ok, n_err, n_done, n_empty, n_num, n_val, n_inv;
	bit full_seen, trunc_seen;
	logic [7:0] exp_q[$];
	logic [7:0] body[$];
	string rot_s = "VDROT,1688,,A,V";
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	// short bit times keep the run brief; expectations do not depend on them
	msf_top #(.BIT_STD(16), .BIT_HS(8)) DUT (
		.clock_i(clock_i), .resetn_i(resetn_i), .hs_sel_i(hs_sel_i), .tx_data_i(tx_data_i),
		.tx_kind_i(tx_kind_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_bang_i(tx_bang_i),
		.tx_line_o(tx_line_o), .tx_busy_o(tx_busy_o), .tx_trunc_o(tx_trunc_o), .rx_line_i(rx_line_i),
		.rx_char_o(rx_char_o), .rx_field_o(rx_field_o), .rx_char_valid_o(rx_char_valid_o),
		.rx_fld_done_o(rx_fld_done_o), .rx_fld_len_o(rx_fld_len_o), .rx_fld_empty_o(rx_fld_empty_o),
		.rx_fld_num_o(rx_fld_num_o), .rx_fld_status_o(rx_fld_status_o), .rx_talker_o(rx_talker_o),
		.rx_sum_o(rx_sum_o), .rx_ok_o(rx_ok_o), .rx_err_o(rx_err_o)
	);
	msf_link_model #(.BIT_STD(16), .BIT_HS(8)) link (
		.clock_i(clock_i), .resetn_i(resetn_i), .hs_i(hs_sel_i), .tx_line_i(tx_line_o), .rx_line_o(rx_line_i)
	);
	// pulses are counted at the falling edge, where they are settled
	always @(negedge clock_i) begin
		if (rx_ok_o === 1'b1) n_ok++;
		if (rx_err_o === 1'b1) n_err++;
		if (tx_trunc_o === 1'b1) trunc_seen = 1'b1;
		if (rx_fld_done_o === 1'b1) begin
			n_done++;
			if (rx_fld_empty_o === 1'b1) n_empty++;
			if (rx_fld_num_o === 1'b1) n_num++;
			if (rx_fld_status_o === MSF_ST_VALID) n_val++;
			if (rx_fld_status_o === MSF_ST_INVALID) n_inv++;
		end
	end
	task automatic conclude();
		if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [7:0] hexc(input logic [3:0] n);
		return n < 4'ha ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction
	task automatic push(input msf_kind_t k, input logic [7:0] d);
		int n;
		n = 0;
		tx_valid_i <= 1'b1;
		tx_kind_i <= k;
		tx_data_i <= d;
		do begin
			@(negedge clock_i);
			n++;
			if (tx_ready_o === 1'b0) full_seen = 1'b1;
		end while (tx_ready_o !== 1'b1 && n < 100000);
		if (n >= 100000) begin
			n_mismatch++;
			conclude();
		end
		@(posedge clock_i);
	endtask
	task automatic tx_sentence(input int len, input bit bang);
		logic [7:0] s, c;
		int cnt, k;
		msf_kind_t kd;
		exp_q.delete();
		link.got.delete();
		s = 8'h00;
		cnt = 0;
		trunc_seen = 1'b0;
		full_seen = 1'b0;
		tx_bang_i <= bang;
		exp_q.push_back(bang ? `MSF_CH_BANG : `MSF_CH_DOLLAR);
		for (int i = 0; i < len; i++) begin
			kd = ($random(seed) & 3) == 0 ? MSF_K_SEP : MSF_K_DATA;
			c = kd == MSF_K_SEP ? `MSF_CH_COMMA : 8'h30 + 8'($random(seed) & 31);
			push(kd, c);
			if (cnt < 76) begin
				exp_q.push_back(c);
				s ^= c;
				cnt++;
			end
		end
		push(MSF_K_END, 8'h00);
		tx_valid_i <= 1'b0;
		k = 0;
		do begin
			@(negedge clock_i);
			k++;
		end while (tx_busy_o !== 1'b0 && k < 100000);
		if (k >= 100000) begin
			n_mismatch++;
			conclude();
		end
		@(posedge clock_i);
		exp_q.push_back(`MSF_CH_STAR);
		exp_q.push_back(hexc(s[7:4]));
		exp_q.push_back(hexc(s[3:0]));
		exp_q.push_back(`MSF_CH_CR);
		exp_q.push_back(`MSF_CH_LF);
		`CHK(link.got.size(), exp_q.size())
		foreach (exp_q[i]) `CHK(link.got[i], exp_q[i])
		`CHK(trunc_seen, len > 76)
		`CHK(full_seen, 1'b1)
	endtask
	task automatic rx_sentence(input bit bang, input logic [7:0] skew, input bit exp_ok);
		logic [7:0] s;
		s = skew;
		foreach (body[i]) s ^= body[i];
		n_ok = 0;
		n_err = 0;
		n_done = 0;
		n_empty = 0;
		n_num = 0;
		n_val = 0;
		n_inv = 0;
		link.send_byte(bang ? `MSF_CH_BANG : `MSF_CH_DOLLAR);
		foreach (body[i]) link.send_byte(body[i]);
		link.send_byte(`MSF_CH_STAR);
		link.send_byte(hexc(s[7:4]));
		link.send_byte(hexc(s[3:0]));
		link.send_byte(`MSF_CH_CR);
		link.send_byte(`MSF_CH_LF);
		repeat (4) @(posedge clock_i);
		`CHK(n_ok, exp_ok ? 1 : 0)
		`CHK(n_err, exp_ok ? 0 : 1)
		if (exp_ok) `CHK(rx_sum_o, s)
	endtask
	initial begin
		seed = 32'hd426;
		n_mismatch = 0;
		comparisons = 0;
		resetn_i = 1'b0;
		hs_sel_i = 1'b0;
		tx_valid_i = 1'b0;
		tx_bang_i = 1'b0;
		tx_kind_i = MSF_K_DATA;
		tx_data_i = 8'h00;
		repeat (16) @(posedge clock_i);
		resetn_i <= 1'b1;
		@(posedge clock_i);
		for (int h = 0; h < 3; h++) begin
			hs_sel_i <= h != 0;
			@(posedge clock_i);
			tx_sentence(h == 2 ? 80 : 12 + ($random(seed) & 15), h == 1);
		end
		hs_sel_i <= 1'b0;
		@(posedge clock_i);
		for (int i = 0; i < rot_s.len(); i++) body.push_back(rot_s[i]);
		rx_sentence(1'b0, 8'h00, 1'b1);
		`CHK(rx_talker_o, 16'h5644)
		`CHK(n_done, 5)
		`CHK(n_empty, 1)
		`CHK(n_num, 1)
		`CHK(n_val, 1)
		`CHK(n_inv, 1)
		`CHK(rx_char_o, 8'h56)
		`CHK(rx_field_o, 7'h05)
		`CHK(rx_fld_len_o, 7'h01)
		hs_sel_i <= 1'b1;
		@(posedge clock_i);
		// good, corrupted, and a dollar wrongly folded into the sum of a bang sentence
		for (int i = 0; i < 3; i++) rx_sentence(1'b1, i == 0 ? 8'h00 : i == 1 ? 8'h01 : `MSF_CH_DOLLAR, i == 0);
		for (int n = 76; n < 78; n++) begin
			body.delete();
			repeat (n) body.push_back(8'h30 + 8'($random(seed) & 31));
			rx_sentence(1'b0, 8'h00, n == 76);
		end
		conclude();
	end
endmodule // testbench

// File: dv/msf_top_asserts.sv
// concurrent checks on the marine sentence framer ports
`timescale 1ns/1ps
module msf_chk import msf_pkg::*; #(
	parameter int BIT_STD = 16,
	parameter int BIT_HS = 8
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hs_sel_i,
	input wire logic [7:0] tx_data_i,
	input wire msf_kind_t tx_kind_i,
	input wire logic tx_valid_i,
	input wire logic tx_ready_o,
	input wire logic tx_bang_i,
	input wire logic tx_line_o,
	input wire logic tx_busy_o,
	input wire logic tx_trunc_o,
	input wire logic rx_line_i,
	input wire logic [7:0] rx_char_o,
	input wire logic [6:0] rx_field_o,
	input wire logic rx_char_valid_o,
	input wire logic rx_fld_done_o,
	input wire logic [6:0] rx_fld_len_o,
	input wire logic rx_fld_empty_o,
	input wire logic rx_fld_num_o,
	input wire msf_status_t rx_fld_status_o,
	input wire logic [15:0] rx_talker_o,
	input wire logic [7:0] rx_sum_o,
	input wire logic rx_ok_o,
	input wire logic rx_err_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// length of the current low run on the serial output
	int low_run;
	always_ff @(posedge clock_i) begin
		if (!resetn_i || tx_line_o) low_run <= 0;
		else low_run <= low_run + 1;
	end
	rst_vals_a: assert property (disable iff (1'b0) !resetn_i |=> tx_line_o && tx_ready_o && !tx_busy_o && !rx_ok_o)
		else $error("outputs not at rest after reset");
	idle_high_a: assert property (!tx_busy_o |-> tx_line_o)
		else $error("serial output low while idle");
	bit_len_a: assert property ($rose(tx_line_o) |-> low_run > 0 && low_run % (hs_sel_i ? BIT_HS : BIT_STD) == 0)
		else $error("low run not a whole number of bits");
	ok_err_excl_a: assert property (!(rx_ok_o && rx_err_o))
		else $error("sentence both accepted and rejected");
	empty_len_a: assert property (rx_fld_done_o |-> rx_fld_empty_o == (rx_fld_len_o == 7'h00))
		else $error("empty flag disagrees with length");
	field_step_a: assert property (rx_fld_done_o |-> rx_field_o == $past(rx_field_o) + 7'h01)
		else $error("field index did not step");
	status_len_a: assert property (rx_fld_done_o && rx_fld_status_o != MSF_ST_NONE |-> rx_fld_len_o == 7'h01)
		else $error("status on a field longer than one");
	num_nonempty_a: assert property (rx_fld_done_o && rx_fld_num_o |-> !rx_fld_empty_o)
		else $error("empty field marked numeric");
	char_not_sep_a: assert property (rx_char_valid_o |-> rx_char_o != 8'h2c && rx_char_o != 8'h2a)
		else $error("separator delivered as body character");
	// dropped words can follow each other, so only busy and an idle line during a drop are checked
	trunc_pulse_a: assert property (tx_trunc_o |-> tx_busy_o && tx_line_o)
		else $error("truncation pulse malformed");
	cover property (rx_ok_o);
	cover property (rx_err_o);
	cover property (tx_trunc_o);
	cover property (rx_fld_done_o && rx_fld_empty_o);
endmodule // msf_chk

bind msf_top msf_chk #(.BIT_STD(BIT_STD), .BIT_HS(BIT_HS)) u_chk (
	.clock_i(clock_i), .resetn_i(resetn_i), .hs_sel_i(hs_sel_i), .tx_data_i(tx_data_i),
	.tx_kind_i(tx_kind_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_bang_i(tx_bang_i),
	.tx_line_o(tx_line_o), .tx_busy_o(tx_busy_o), .tx_trunc_o(tx_trunc_o), .rx_line_i(rx_line_i),
	.rx_char_o(rx_char_o), .rx_field_o(rx_field_o), .rx_char_valid_o(rx_char_valid_o),
	.rx_fld_done_o(rx_fld_done_o), .rx_fld_len_o(rx_fld_len_o), .rx_fld_empty_o(rx_fld_empty_o),
	.rx_fld_num_o(rx_fld_num_o), .rx_fld_status_o(rx_fld_status_o), .rx_talker_o(rx_talker_o),
	.rx_sum_o(rx_sum_o), .rx_ok_o(rx_ok_o), .rx_err_o(rx_err_o)
);

// File: hdl/msf_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module msf_fifo #(
	parameter int W = 10,
	parameter int DEPTH = 4
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	msf_stream_if.snk in_s,
	msf_stream_if.src out_s
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [CW-1:0] cnt_r;
	logic push;
	logic pull;

	assign in_s.ready = (cnt_r != CW'(DEPTH));
	assign out_s.valid = (cnt_r != '0);
	assign out_s.data = mem[rd_r];
	assign push = in_s.valid && in_s.ready;
	assign pull = out_s.valid && out_s.ready;

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_r] <= in_s.data;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
			end
			if (pull) begin
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + CW'(push) - CW'(pull);
		end
	end
endmodule // msf_fifo

// File: hdl/msf_params.svh
// constants of the marine sentence framer: rates, limits and character codes
`ifndef MSF_PARAMS_SVH
`define MSF_PARAMS_SVH

// ----------------------------------------
// clock and bit rates
// ----------------------------------------
`define MSF_CLK_HZ 20000000
`define MSF_BAUD_STD 4800
`define MSF_BAUD_HS 38400

// ----------------------------------------
// sentence limits
// ----------------------------------------
`define MSF_MAX_CHARS 80
`define MSF_FRAME_OVH 4
`define MSF_TALKER_LEN 2
`define MSF_FIFO_DEPTH 4

// ----------------------------------------
// character codes
// ----------------------------------------
`define MSF_CH_DOLLAR 8'h24
`define MSF_CH_BANG 8'h21
`define MSF_CH_STAR 8'h2a
`define MSF_CH_COMMA 8'h2c
`define MSF_CH_CR 8'h0d
`define MSF_CH_LF 8'h0a
`define MSF_CH_VALID 8'h41
`define MSF_CH_INVALID 8'h56

`endif

// File: hdl/msf_pkg.sv
// types shared by the marine sentence framer modules
package msf_pkg;
	typedef enum logic [1:0] {
		MSF_K_DATA = 2'h0,
		MSF_K_SEP = 2'h1,
		MSF_K_END = 2'h2
	} msf_kind_t;

	typedef struct packed {
		msf_kind_t kind;
		logic [7:0] ch;
	} msf_word_t;

	typedef enum logic [1:0] {
		MSF_ST_NONE = 2'h0,
		MSF_ST_VALID = 2'h1,
		MSF_ST_INVALID = 2'h2
	} msf_status_t;
endpackage

// File: hdl/msf_stream_if.sv
// valid/ready stream carrier between the framer and its queue
`timescale 1ns/1ps
interface msf_stream_if #(parameter int W = 10);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface // msf_stream_if

// File: hdl/msf_top.sv
// marine sentence framer: builds and checks delimited, checksummed ascii sentences
// Operation
// [RL1] characters are 8 data bits, no parity, one stop, at 4800 bit/s
// [RL2] same format at 38400 bit/s, speed selectable between the two
// [RL3] single talker per link; receiver only listens, never drives the line
// [RL4] sentences open with dollar or bang and close with cr then lf
// [RL5] at most 80 characters before cr lf; longer ones rejected
// [RL6] transmitter keeps items on one line, separated by commas
// [RL7] receiver finds fields by counting commas only
// [RL8] numeric fields of any digit count are accepted
// [RL9] empty field is reported absent, not an error
// [RL10] checksum always appended on send and required on receive
// [RL11] checksum is xor of all characters between start and asterisk
// [RL12] start character never enters the checksum
// [RL13] one-character status field: A valid, V invalid
// [RL14] hex fields carry fixed digit count, most significant first
// [RL15] fixed-number field is integer with fixed digit count
// [RL16] first two characters after start name the talker
// [RL17] checksum sent as asterisk plus two uppercase hex, high first
// [RL18] bad checksum or overlong sentence discarded with error flag
// [RL19] lsb first, low start bit, line high when idle
`timescale 1ns/1ps
`include "msf_params.svh"
module msf_top import msf_pkg::*; #(
	parameter int CLK_HZ = `MSF_CLK_HZ,
	parameter int BIT_STD = (CLK_HZ + `MSF_BAUD_STD / 2) / `MSF_BAUD_STD,
	parameter int BIT_HS = (CLK_HZ + `MSF_BAUD_HS / 2) / `MSF_BAUD_HS,
	parameter int FIFO_DEPTH = `MSF_FIFO_DEPTH
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hs_sel_i,
	input wire logic [7:0] tx_data_i,
	input wire msf_kind_t tx_kind_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic tx_bang_i,
	output logic tx_line_o,
	output logic tx_busy_o,
	output logic tx_trunc_o,
	input wire logic rx_line_i,
	output logic [7:0] rx_char_o,
	output logic [6:0] rx_field_o,
	output logic rx_char_valid_o,
	output logic rx_fld_done_o,
	output logic [6:0] rx_fld_len_o,
	output logic rx_fld_empty_o,
	output logic rx_fld_num_o,
	output msf_status_t rx_fld_status_o,
	output logic [15:0] rx_talker_o,
	output logic [7:0] rx_sum_o,
	output logic rx_ok_o,
	output logic rx_err_o
);
	localparam int CW = $clog2(BIT_STD + 1);
	localparam logic [6:0] BODY_MAX = 7'(`MSF_MAX_CHARS - `MSF_FRAME_OVH);

	typedef enum {TS_IDLE, TS_BODY, TS_STAR, TS_HI, TS_LO, TS_CR, TS_LF} msf_tx_state_t;
	typedef enum {RP_HUNT, RP_BODY, RP_HI, RP_LO, RP_CR, RP_LF} msf_rp_state_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] hex_ch(input logic [3:0] n);
		hex_ch = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction

	function automatic logic is_hex(input logic [7:0] c);
		is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		hex_val = (c <= 8'h39) ? c[3:0] : 4'(c[3:0] + 4'h9);
	endfunction

	function automatic logic is_start(input logic [7:0] c);
		is_start = (c == `MSF_CH_DOLLAR) || (c == `MSF_CH_BANG);
	endfunction

	// ----------------------------------------
	// transmit queue
	// ----------------------------------------
	msf_stream_if #(.W($bits(msf_word_t))) txq_in ();
	msf_stream_if #(.W($bits(msf_word_t))) txq_out ();

	msf_word_t qw;
	logic pop;

	assign txq_in.valid = tx_valid_i;
	assign txq_in.data = {tx_kind_i, tx_data_i};
	assign tx_ready_o = txq_in.ready;
	assign txq_out.ready = pop;
	assign qw = msf_word_t'(txq_out.data);

	msf_fifo #(.W($bits(msf_word_t)), .DEPTH(FIFO_DEPTH)) u_txq (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.in_s(txq_in),
		.out_s(txq_out)
	);

	// ----------------------------------------
	// transmit serialiser
	// ----------------------------------------
	logic [CW-1:0] bit_len;
	logic [CW-1:0] tcnt_r;
	logic [9:0] tsh_r;
	logic [3:0] tnb_r;
	logic tbusy_r;
	logic tick;
	logic load;
	logic [7:0] tch;

	assign bit_len = hs_sel_i ? CW'(BIT_HS) : CW'(BIT_STD); // RL2
	assign tick = tbusy_r && (tcnt_r == bit_len - 1'b1);
	assign tx_line_o = tsh_r[0]; // RL3

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			tsh_r <= '1;
			tnb_r <= '0;
			tbusy_r <= 1'b0;
			tcnt_r <= '0;
		end else if (load) begin
			tsh_r <= {1'b1, tch, 1'b0}; // RL19 RL1
			tnb_r <= '0;
			tbusy_r <= 1'b1;
			tcnt_r <= '0;
		end else if (tick) begin
			tcnt_r <= '0;
			tsh_r <= {1'b1, tsh_r[9:1]};
			tnb_r <= tnb_r + 1'b1;
			if (tnb_r == 4'h9) begin
				tbusy_r <= 1'b0;
			end
		end else if (tbusy_r) begin
			tcnt_r <= tcnt_r + 1'b1;
		end
	end

	// ----------------------------------------
	// transmit sentence builder
	// ----------------------------------------
	msf_tx_state_t ts_r;
	logic [7:0] tsum_r;
	logic [6:0] tlen_r;
	logic tfull;

	// payload beyond the limit is dropped so the closing stays intact
	assign tfull = (tlen_r >= BODY_MAX); // RL5
	assign tx_busy_o = (ts_r != TS_IDLE) || tbusy_r;

	always_comb begin
		load = 1'b0;
		pop = 1'b0;
		tch = 8'h00;
		if (!tbusy_r) begin
			unique case (ts_r)
				TS_IDLE: begin
					load = txq_out.valid;
					tch = tx_bang_i ? `MSF_CH_BANG : `MSF_CH_DOLLAR; // RL4
				end
				TS_BODY: begin
					pop = txq_out.valid;
					if (qw.kind == MSF_K_DATA) begin
						load = txq_out.valid && !tfull;
						tch = qw.ch;
					end else if (qw.kind == MSF_K_SEP) begin
						load = txq_out.valid && !tfull;
						tch = `MSF_CH_COMMA; // RL6
					end
				end
				TS_STAR: begin
					load = 1'b1;
					tch = `MSF_CH_STAR; // RL10
				end
				TS_HI: begin
					load = 1'b1;
					tch = hex_ch(tsum_r[7:4]); // RL17
				end
				TS_LO: begin
					load = 1'b1;
					tch = hex_ch(tsum_r[3:0]); // RL17
				end
				TS_CR: begin
					load = 1'b1;
					tch = `MSF_CH_CR;
				end
				TS_LF: begin
					load = 1'b1;
					tch = `MSF_CH_LF; // RL4
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ts_r <= TS_IDLE;
			tsum_r <= '0;
			tlen_r <= '0;
			tx_trunc_o <= 1'b0;
		end else begin
			tx_trunc_o <= 1'b0;
			unique case (ts_r)
				TS_IDLE: begin
					tsum_r <= '0; // RL12
					tlen_r <= '0;
					if (load) begin
						ts_r <= TS_BODY;
					end
				end
				TS_BODY: begin
					if (load) begin
						tsum_r <= tsum_r ^ tch; // RL11
						tlen_r <= tlen_r + 1'b1;
					end
					if (pop && qw.kind == MSF_K_END) begin
						ts_r <= TS_STAR;
					end else if (pop && !load) begin
						tx_trunc_o <= 1'b1;
					end
				end
				TS_STAR: ts_r <= load ? TS_HI : TS_STAR;
				TS_HI: ts_r <= load ? TS_LO : TS_HI;
				TS_LO: ts_r <= load ? TS_CR : TS_LO;
				TS_CR: ts_r <= load ? TS_LF : TS_CR;
				TS_LF: ts_r <= load ? TS_IDLE : TS_LF;
			endcase
		end
	end

	// ----------------------------------------
	// receive path
	// ----------------------------------------
	logic [7:0] rb;
	logic rb_v;
	logic rb_ferr;

	msf_uart_rx #(.BIT_STD(BIT_STD), .BIT_HS(BIT_HS)) u_rx (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.hs_i(hs_sel_i),
		.line_i(rx_line_i),
		.byte_o(rb),
		.byte_valid_o(rb_v),
		.frame_err_o(rb_ferr)
	);

	msf_rp_state_t rp_r;
	logic [7:0] rsum_r;
	logic [6:0] rlen_r;
	logic [6:0] flen_r;
	logic fnum_r;
	logic [7:0] fch_r;
	logic [3:0] rhi_r;
	logic fld_end;

	assign fld_end = rb_v && rp_r == RP_BODY && (rb == `MSF_CH_COMMA || rb == `MSF_CH_STAR);

	// field boundaries come only from separators, never from column positions
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rx_char_o <= '0;
			rx_field_o <= '0;
			rx_char_valid_o <= 1'b0;
			rx_fld_done_o <= 1'b0;
			rx_fld_len_o <= '0;
			rx_fld_empty_o <= 1'b0;
			rx_fld_num_o <= 1'b0;
			rx_fld_status_o <= MSF_ST_NONE;
			flen_r <= '0;
			fnum_r <= 1'b1;
			fch_r <= '0;
		end else begin
			rx_char_valid_o <= 1'b0;
			rx_fld_done_o <= 1'b0;
			if (rb_v && is_start(rb)) begin
				rx_field_o <= '0;
				flen_r <= '0;
				fnum_r <= 1'b1;
			end else if (fld_end) begin
				rx_fld_done_o <= 1'b1;
				rx_fld_len_o <= flen_r;
				rx_fld_empty_o <= (flen_r == '0); // RL9
				rx_fld_num_o <= fnum_r && (flen_r != '0); // RL8 RL15
				if (flen_r == 7'h1 && fch_r == `MSF_CH_VALID) begin
					rx_fld_status_o <= MSF_ST_VALID; // RL13
				end else if (flen_r == 7'h1 && fch_r == `MSF_CH_INVALID) begin
					rx_fld_status_o <= MSF_ST_INVALID; // RL13
				end else begin
					rx_fld_status_o <= MSF_ST_NONE;
				end
				rx_field_o <= rx_field_o + 1'b1; // RL7
				flen_r <= '0;
				fnum_r <= 1'b1;
			end else if (rb_v && rp_r == RP_BODY) begin
				rx_char_o <= rb;
				rx_char_valid_o <= 1'b1;
				fch_r <= rb;
				flen_r <= flen_r + 1'b1;
				fnum_r <= fnum_r && (rb >= 8'h30 && rb <= 8'h39);
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			rp_r <= RP_HUNT;
			rsum_r <= '0;
			rlen_r <= '0;
			rhi_r <= '0;
			rx_talker_o <= '0;
			rx_sum_o <= '0;
			rx_ok_o <= 1'b0;
			rx_err_o <= 1'b0;
		end else begin
			rx_ok_o <= 1'b0;
			rx_err_o <= 1'b0;
			if (rb_ferr && rp_r != RP_HUNT) begin
				rp_r <= RP_HUNT;
				rx_err_o <= 1'b1;
			end else if (rb_v && is_start(rb)) begin
				// a fresh start aborts any sentence in progress
				rp_r <= RP_BODY; // RL4
				rsum_r <= '0; // RL12
				rlen_r <= '0;
				rx_err_o <= (rp_r != RP_HUNT);
			end else if (rb_v) begin
				unique case (rp_r)
					RP_HUNT: ;
					RP_BODY: begin
						if (rb == `MSF_CH_STAR) begin
							rp_r <= RP_HI;
						end else if (rb == `MSF_CH_CR || rb == `MSF_CH_LF || rlen_r >= BODY_MAX) begin
							rp_r <= RP_HUNT; // RL10 RL5 RL18
							rx_err_o <= 1'b1;
						end else begin
							rsum_r <= rsum_r ^ rb; // RL11
							rlen_r <= rlen_r + 1'b1;
							if (rlen_r < 7'(`MSF_TALKER_LEN)) begin
								rx_talker_o <= {rx_talker_o[7:0], rb}; // RL16
							end
						end
					end
					RP_HI: begin
						rhi_r <= hex_val(rb); // RL14
						rp_r <= is_hex(rb) ? RP_LO : RP_HUNT;
						rx_err_o <= !is_hex(rb);
					end
					RP_LO: begin
						rx_sum_o <= {rhi_r, hex_val(rb)}; // RL14
						rp_r <= is_hex(rb) ? RP_CR : RP_HUNT;
						rx_err_o <= !is_hex(rb);
					end
					RP_CR: begin
						rp_r <= (rb == `MSF_CH_CR) ? RP_LF : RP_HUNT;
						rx_err_o <= (rb != `MSF_CH_CR);
					end
					RP_LF: begin
						rp_r <= RP_HUNT;
						rx_ok_o <= (rb == `MSF_CH_LF) && (rx_sum_o == rsum_r);
						rx_err_o <= !((rb == `MSF_CH_LF) && (rx_sum_o == rsum_r)); // RL18
					end
				endcase
			end
		end
	end
endmodule // msf_top

// File: hdl/msf_uart_rx.sv
// serial character receiver: pin synchroniser and 8N1 deframer
`timescale 1ns/1ps
module msf_uart_rx #(
	parameter int BIT_STD = 4167,
	parameter int BIT_HS = 521
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic hs_i,
	input wire logic line_i,
	output logic [7:0] byte_o,
	output logic byte_valid_o,
	output logic frame_err_o
);
	localparam int CW = $clog2(BIT_STD + 1);

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} msf_rx_state_t;

	msf_rx_state_t st_r;
	logic s1_r, s2_r, s3_r, lvl_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] bit_len;
	logic [2:0] nbit_r;
	logic [7:0] sh_r;

	assign bit_len = hs_i ? CW'(BIT_HS) : CW'(BIT_STD);

	// ----------------------------------------
	// pin synchroniser; line idles high
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
			lvl_r <= 1'b1;
		end else begin
			s1_r <= line_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				lvl_r <= s3_r;
			end
		end
	end

	// ----------------------------------------
	// deframer: sample mid bit, lsb first
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			st_r <= RX_IDLE;
			cnt_r <= '0;
			nbit_r <= '0;
			sh_r <= '0;
			byte_o <= '0;
			byte_valid_o <= 1'b0;
			frame_err_o <= 1'b0;
		end else begin
			byte_valid_o <= 1'b0;
			frame_err_o <= 1'b0;
			unique case (st_r)
				RX_IDLE: begin
					cnt_r <= '0;
					if (!lvl_r) begin
						st_r <= RX_START;
					end
				end
				RX_START: begin
					if (cnt_r == (bit_len >> 1)) begin
						cnt_r <= '0;
						nbit_r <= '0;
						st_r <= lvl_r ? RX_IDLE : RX_DATA;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				RX_DATA: begin
					if (cnt_r == bit_len - 1'b1) begin
						cnt_r <= '0;
						sh_r <= {lvl_r, sh_r[7:1]}; // RL19
						nbit_r <= nbit_r + 1'b1;
						if (nbit_r == 3'h7) begin
							st_r <= RX_STOP;
						end
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				RX_STOP: begin
					if (cnt_r == bit_len - 1'b1) begin
						st_r <= RX_IDLE;
						byte_o <= sh_r;
						byte_valid_o <= lvl_r; // RL1
						frame_err_o <= !lvl_r;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
			endcase
		end
	end
endmodule // msf_uart_rx
